// ---- hw/direct_mode_control.sv ----
// Function
// - parallel port: writing direct bit high enters direct mode at once.
// - host omits stop after enabling write; a stop condition ends parallel direct mode.
// - in direct mode the modulation and rx enable pins (and in SPI the serial out pin) become direct signals; no register traffic except the SPI exit write to 00.
// - after the terminating stop, normal register access resumes.
// - SPI: direct bit written, then chip select rising enters direct mode.
// - SPI: exit only by chip select low and writing register 00 direct low.
// - SPI direct mode: no reads; serial out carries receive data.
// - direct mode: RF level follows the modulation input pin.
// - external shaping only when its bit is set and direct mode active.
// - ASK depth from 6-bit field, 01 to 3F; separate 5-bit level.
// - phase reversal select turns depth field into 9.6 to 15.9 us delimiter.
// - linear or sinusoidal shape, 2-bit rate trim, optional low-pass filter.
// - on-off delimiter bit: full depth, depth field sets delimiter length.
// - routing bits pick modulated outputs; others enabled carry plain carrier.
// - register 0B: low-power enable/current, PA enable, differential PA.
// - register 0A: attenuator widens mixer range; low-supply operating point.
// - differential mixer input unless single-ended select bit is set.
`timescale 1ns/1ps
module direct_mode_control
   import direct_mode_pkg::*;
#(
   parameter int DELIM_W = 12
) (
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   input  wire logic               spi_mode_i,
   input  wire logic               wr_i,
   input  wire logic [7:0]         wr_addr_i,
   input  wire logic [7:0]         wr_data_i,
   input  wire logic               rd_i,
   input  wire logic [7:0]         rd_addr_i,
   output logic                    rd_valid_o,
   output logic [7:0]              rd_data_o,
   input  wire logic               stop_i,
   input  wire logic               chip_select_pin_i,
   input  wire logic               rx_enable_pin_i,
   input  wire logic               modulation_input_pin_i,
   input  wire logic               spi_miso_i,
   input  wire logic               rx_direct_data_i,
   input  wire logic               coder_mod_i,
   input  wire logic               coder_rx_enable_i,
   output logic                    serial_out_direct_pin_o,
   output logic                    serial_out_direct_pin_oe_o,
   output logic                    direct_active_o,
   output logic                    rf_level_high_o,
   output logic                    rx_enable_o,
   output logic                    ext_shaping_o,
   output logic                    phase_reversal_o,
   output logic [5:0]              ask_depth_o,
   output logic [DELIM_W-1:0]      delimiter_cycles_o,
   output logic                    delimiter_timed_o,
   output logic [4:0]              tx_level_o,
   output logic                    linear_shape_o,
   output logic [1:0]              ask_rate_o,
   output logic                    lpf_enable_o,
   output logic                    aux_enable_o,
   output logic                    aux_modulated_o,
   output logic                    main_enable_o,
   output logic                    main_modulated_o,
   output logic [1:0]              lp_current_o,
   output logic [1:0]              pa_enable_o,
   output logic                    pa_differential_o,
   output logic                    mixer_attenuator_o,
   output logic                    mixer_low_supply_o,
   output logic                    mixer_single_ended_o
);

   localparam int DELIM_MAX_CYC = DELIM_MIN_CYC + int'(DEPTH_FULL) * DELIM_STEP_CYC;

   // refused at elaboration: a narrow count would wrap long delimiters short
   if (DELIM_MAX_CYC >= (1 << DELIM_W)) begin
      $error("DELIM_W too narrow for delimiter timing");
   end

   typedef struct packed {
      link_mode_type           mode;
      logic                    cs_prev;
      logic                    cs_fell;
      logic [7:0]              chip_status_control;
      logic [7:0]              rx_special_setting_two;
      logic [7:0]              regulator_io_control;
      logic [7:0]              modulator_control;
      logic [7:0]              modulator_shape;
      logic [7:0]              modulator_routing;
      logic                    rd_valid;
      logic [7:0]              rd_data;
      logic                    rf_level;
      logic                    rx_enable;
      logic                    serial_out;
      logic [5:0]              ask_depth;
      logic [DELIM_W-1:0]      delim_cycles;
   } state_type;

   state_type state_reg;
   state_type state_next;

   logic       direct;
   logic       cs_rise;
   logic       wr_chip;
   logic [5:0] depth_field;
   logic       timed_delim;

   assign direct      = (state_reg.mode == MODE_DIRECT);
   assign cs_rise     = chip_select_pin_i & ~state_reg.cs_prev;
   assign wr_chip     = wr_i && (wr_addr_i == CHIP_STATUS_CONTROL_ADDR);
   assign depth_field = state_reg.modulator_control[MOD_DEPTH_LSB +: 6];
   assign timed_delim = state_reg.modulator_control[PHASE_REV_BIT]
                        | state_reg.modulator_control[ON_OFF_DELIM_BIT];

   always_comb begin
      state_next = state_reg;
      state_next.cs_prev = chip_select_pin_i;
      state_next.rd_valid = 1'b0;

      // register writes: refused in direct mode except the SPI exit write
      if (wr_i && !direct) begin
         unique case (wr_addr_i)
            CHIP_STATUS_CONTROL_ADDR: begin
               state_next.chip_status_control = wr_data_i;
            end
            RX_SPECIAL_SETTING_TWO_ADDR: begin
               state_next.rx_special_setting_two = wr_data_i;
            end
            REGULATOR_IO_CONTROL_ADDR: begin
               state_next.regulator_io_control = wr_data_i;
            end
            MODULATOR_CONTROL_ADDR: begin
               state_next.modulator_control = wr_data_i;
            end
            MODULATOR_SHAPE_ADDR: begin
               state_next.modulator_shape = wr_data_i;
            end
            MODULATOR_ROUTING_ADDR: begin
               state_next.modulator_routing = wr_data_i;
            end
            default: ;
         endcase
      end

      // reads answered one cycle later; none while the pins are repurposed
      if (rd_i && !direct) begin
         state_next.rd_valid = 1'b1;
         unique case (rd_addr_i)
            CHIP_STATUS_CONTROL_ADDR: begin
               state_next.rd_data = state_reg.chip_status_control;
            end
            RX_SPECIAL_SETTING_TWO_ADDR: begin
               state_next.rd_data = state_reg.rx_special_setting_two;
            end
            REGULATOR_IO_CONTROL_ADDR: begin
               state_next.rd_data = state_reg.regulator_io_control;
            end
            MODULATOR_CONTROL_ADDR: begin
               state_next.rd_data = state_reg.modulator_control;
            end
            MODULATOR_SHAPE_ADDR: begin
               state_next.rd_data = state_reg.modulator_shape;
            end
            MODULATOR_ROUTING_ADDR: begin
               state_next.rd_data = state_reg.modulator_routing;
            end
            // unmapped offsets read as zero rather than stale data
            default: begin
               state_next.rd_data = 8'h00;
            end
         endcase
      end

      unique case (state_reg.mode)
         MODE_NORMAL: begin
            if (wr_chip && wr_data_i[DIRECT_BIT]) begin
               // parallel takes effect now; SPI waits for the chip select rise
               if (spi_mode_i) begin
                  state_next.mode = MODE_ARMED;
               end else begin
                  state_next.mode = MODE_DIRECT;
               end
            end
         end
         MODE_ARMED: begin
            if (wr_chip && !wr_data_i[DIRECT_BIT]) begin
               state_next.mode = MODE_NORMAL;
            end else if (cs_rise) begin
               state_next.mode = MODE_DIRECT;
               state_next.cs_fell = 1'b0;
            end
         end
         MODE_DIRECT: begin
            if (!spi_mode_i) begin
               if (stop_i) begin
                  state_next.mode = MODE_NORMAL;
                  state_next.chip_status_control[DIRECT_BIT] = 1'b0;
               end
            end else begin
               if (!chip_select_pin_i) begin
                  state_next.cs_fell = 1'b1;
               end
               // only register 00 may be written, and only after select dropped
               if (state_reg.cs_fell && wr_chip && !wr_data_i[DIRECT_BIT]) begin
                  state_next.mode = MODE_NORMAL;
                  state_next.chip_status_control = wr_data_i;
                  state_next.cs_fell = 1'b0;
               end
            end
         end
      endcase

      // pins repurposed for the direct signals
      state_next.rf_level  = direct ? modulation_input_pin_i : coder_mod_i;
      state_next.rx_enable = direct ? rx_enable_pin_i : coder_rx_enable_i;
      state_next.serial_out = (direct && spi_mode_i) ? rx_direct_data_i : spi_miso_i;

      // depth: 00 is not a legal ASK depth, so it is raised to the smallest step
      if (state_reg.modulator_control[ON_OFF_DELIM_BIT]) begin
         state_next.ask_depth = DEPTH_FULL;
      end else if (depth_field < DEPTH_MIN) begin
         state_next.ask_depth = DEPTH_MIN;
      end else begin
         state_next.ask_depth = depth_field;
      end

      // 0.1 us per code step from 9.6 us
      state_next.delim_cycles = DELIM_W'(DELIM_MIN_CYC)
                                + DELIM_W'(depth_field) * DELIM_W'(DELIM_STEP_CYC);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg.mode                   <= MODE_NORMAL;
         state_reg.cs_prev                <= 1'b1;
         state_reg.cs_fell                <= 1'b0;
         state_reg.chip_status_control    <= CHIP_STATUS_CONTROL_RST;
         state_reg.rx_special_setting_two <= RX_SPECIAL_SETTING_TWO_RST;
         state_reg.regulator_io_control   <= REGULATOR_IO_CONTROL_RST;
         state_reg.modulator_control      <= MODULATOR_CONTROL_RST;
         state_reg.modulator_shape        <= MODULATOR_SHAPE_RST;
         state_reg.modulator_routing      <= MODULATOR_ROUTING_RST;
         state_reg.rd_valid               <= 1'b0;
         state_reg.rd_data                <= 8'h00;
         state_reg.rf_level               <= 1'b0;
         state_reg.rx_enable              <= 1'b0;
         state_reg.serial_out             <= 1'b0;
         state_reg.ask_depth              <= DEPTH_MIN;
         state_reg.delim_cycles           <= DELIM_W'(DELIM_MIN_CYC);
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_valid_o                 = state_reg.rd_valid;
   assign rd_data_o                  = state_reg.rd_data;
   assign serial_out_direct_pin_o    = state_reg.serial_out;
   // parallel direct mode releases this pin as the serial line is unused there
   assign serial_out_direct_pin_oe_o = spi_mode_i;
   assign direct_active_o            = direct;
   assign rf_level_high_o            = state_reg.rf_level;
   assign rx_enable_o                = state_reg.rx_enable;

   assign ext_shaping_o    = state_reg.modulator_routing[EXT_SHAPE_BIT] & direct;
   assign phase_reversal_o = state_reg.modulator_control[PHASE_REV_BIT];
   assign ask_depth_o      = state_reg.ask_depth;
   assign delimiter_cycles_o = state_reg.delim_cycles;
   assign delimiter_timed_o  = timed_delim;
   assign tx_level_o       = state_reg.modulator_shape[TX_LEVEL_LSB +: 5];
   assign linear_shape_o   = state_reg.modulator_shape[LIN_SHAPE_BIT];
   assign ask_rate_o       = state_reg.modulator_shape[ASK_RATE_LSB +: 2];
   assign lpf_enable_o     = state_reg.modulator_routing[LPF_ENABLE_BIT];

   // enabled but unrouted outputs carry unmodulated carrier
   assign aux_enable_o     = |state_reg.regulator_io_control[LP_ENABLE_LSB +: 2];
   assign main_enable_o    = |state_reg.regulator_io_control[PA_ENABLE_LSB +: 2];
   assign aux_modulated_o  = aux_enable_o
                             & state_reg.modulator_routing[AUX_MOD_BIT];
   assign main_modulated_o = main_enable_o
                             & state_reg.modulator_routing[MAIN_MOD_BIT];
   assign lp_current_o      = state_reg.regulator_io_control[LP_ENABLE_LSB +: 2];
   assign pa_enable_o       = state_reg.regulator_io_control[PA_ENABLE_LSB +: 2];
   assign pa_differential_o = state_reg.regulator_io_control[PA_DIFF_BIT];

   assign mixer_attenuator_o   = state_reg.rx_special_setting_two[IR_ATTEN_BIT];
   assign mixer_low_supply_o   = state_reg.rx_special_setting_two[IR_LOW_SUPPLY_BIT];
   assign mixer_single_ended_o = state_reg.rx_special_setting_two[SINGLE_MIX_BIT];

endmodule

// ---- pkg/direct_mode_pkg.sv ----
package direct_mode_pkg;

   localparam int CLK_PERIOD_PS = 5000;

   // register offsets
   localparam logic [7:0] CHIP_STATUS_CONTROL_ADDR   = 8'h00;
   localparam logic [7:0] RX_SPECIAL_SETTING_TWO_ADDR = 8'h0A;
   localparam logic [7:0] REGULATOR_IO_CONTROL_ADDR  = 8'h0B;
   localparam logic [7:0] MODULATOR_CONTROL_ADDR     = 8'h15;
   localparam logic [7:0] MODULATOR_SHAPE_ADDR       = 8'h16;
   localparam logic [7:0] MODULATOR_ROUTING_ADDR     = 8'h17;

   // reset values
   localparam logic [7:0] CHIP_STATUS_CONTROL_RST    = 8'h00;
   localparam logic [7:0] RX_SPECIAL_SETTING_TWO_RST = 8'h00;
   localparam logic [7:0] REGULATOR_IO_CONTROL_RST   = 8'h00;
   localparam logic [7:0] MODULATOR_CONTROL_RST      = 8'h00;
   localparam logic [7:0] MODULATOR_SHAPE_RST        = 8'h00;
   localparam logic [7:0] MODULATOR_ROUTING_RST      = 8'h00;

   // chip_status_control
   localparam int DIRECT_BIT       = 6;
   // rx_special_setting_two
   localparam int IR_ATTEN_BIT     = 0;
   localparam int IR_LOW_SUPPLY_BIT = 1;
   localparam int SINGLE_MIX_BIT   = 7;
   // regulator_io_control
   localparam int LP_ENABLE_LSB    = 0;
   localparam int PA_ENABLE_LSB    = 2;
   localparam int PA_DIFF_BIT      = 4;
   // modulator_control
   localparam int MOD_DEPTH_LSB    = 0;
   localparam int PHASE_REV_BIT    = 6;
   localparam int ON_OFF_DELIM_BIT = 7;
   // modulator_shape
   localparam int TX_LEVEL_LSB     = 0;
   localparam int LIN_SHAPE_BIT    = 5;
   localparam int ASK_RATE_LSB     = 6;
   // modulator_routing
   localparam int LPF_ENABLE_BIT   = 0;
   localparam int EXT_SHAPE_BIT    = 1;
   localparam int AUX_MOD_BIT      = 2;
   localparam int MAIN_MOD_BIT     = 3;

   localparam logic [5:0] DEPTH_MIN  = 6'h01;
   localparam logic [5:0] DEPTH_FULL = 6'h3F;

   // delimiter / first zero timing
   localparam int DELIM_MIN_PS  = 9600000;
   localparam int DELIM_STEP_PS = 100000;
   localparam int DELIM_MIN_CYC  = (DELIM_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DELIM_STEP_CYC = DELIM_STEP_PS / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_ARMED,
      MODE_DIRECT
   } link_mode_type;

endpackage

// ---- verif/direct_mode_props.sv ----
`timescale 1ns/1ps
module direct_mode_props
   import direct_mode_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       spi_mode_i,
   input wire logic       wr_i,
   input wire logic [7:0] wr_addr_i,
   input wire logic       rd_i,
   input wire logic       rd_valid_o,
   input wire logic       stop_i,
   input wire logic       chip_select_pin_i,
   input wire logic       modulation_input_pin_i,
   input wire logic       direct_active_o,
   input wire logic       rf_level_high_o,
   input wire logic       ext_shaping_o,
   input wire logic       phase_reversal_o,
   input wire logic [5:0] ask_depth_o,
   input wire logic       delimiter_timed_o,
   input wire logic       aux_enable_o,
   input wire logic       aux_modulated_o,
   input wire logic [7:0] wr_data_i
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   logic wr00;
   assign wr00 = wr_i && (wr_addr_i == CHIP_STATUS_CONTROL_ADDR);
   AST_PAR_ENTER: assert property (
      !spi_mode_i && !direct_active_o && wr00 && wr_data_i[DIRECT_BIT] |=> direct_active_o)
      else $error("parallel entry missed");
   AST_PAR_EXIT: assert property (!spi_mode_i && direct_active_o && stop_i |=> !direct_active_o)
      else $error("stop did not end direct mode");
   AST_SPI_ARMED: assert property (
      spi_mode_i && !direct_active_o && !$rose(chip_select_pin_i) |=> !direct_active_o)
      else $error("spi entry without chip select rise");
   AST_SPI_HOLD: assert property (spi_mode_i && direct_active_o && !wr00 |=> direct_active_o)
      else $error("spi direct mode dropped");
   AST_NO_READ: assert property (direct_active_o && rd_i |=> !rd_valid_o)
      else $error("read answered in direct mode");
   AST_RF_FOLLOW: assert property (
      $past(direct_active_o) |-> rf_level_high_o == $past(modulation_input_pin_i))
      else $error("rf level not following modulation pin");
   AST_EXT_SHAPE: assert property (ext_shaping_o |-> direct_active_o)
      else $error("external shaping outside direct mode");
   AST_DEPTH_NONZERO: assert property (ask_depth_o != 6'h00)
      else $error("depth zero");
   // two samples so a one-cycle decode lag cannot fire falsely
   AST_OOK_FULL: assert property (
      (delimiter_timed_o && !phase_reversal_o) [*2] |-> ask_depth_o == DEPTH_FULL)
      else $error("on-off delimiter without full depth");
   AST_AUX_ROUTE: assert property (aux_modulated_o |-> aux_enable_o)
      else $error("aux modulated while disabled");
   COV_PAR_ENTER: cover property (!spi_mode_i && $rose(direct_active_o));
   COV_SPI_ENTER: cover property (spi_mode_i && $rose(direct_active_o));
   COV_OOK: cover property (delimiter_timed_o && !phase_reversal_o);
endmodule
bind direct_mode_control direct_mode_props u_props (.clk_i(clk_i), .reset_i(reset_i),
   .spi_mode_i(spi_mode_i), .wr_i(wr_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
   .rd_i(rd_i), .rd_valid_o(rd_valid_o), .stop_i(stop_i), .chip_select_pin_i(chip_select_pin_i),
   .modulation_input_pin_i(modulation_input_pin_i), .direct_active_o(direct_active_o),
   .rf_level_high_o(rf_level_high_o), .ext_shaping_o(ext_shaping_o),
   .phase_reversal_o(phase_reversal_o), .ask_depth_o(ask_depth_o),
   .delimiter_timed_o(delimiter_timed_o), .aux_enable_o(aux_enable_o),
   .aux_modulated_o(aux_modulated_o));

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_i,
   input  wire logic       rd_valid_i,
   input  wire logic [7:0] rd_data_i,
   output logic            wr_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      data_o,
   output logic            rd_o,
   output logic            stop_o,
   output logic            cs_o,
   output logic            rx_en_o,
   output logic            mod_o
);
   initial begin
      {wr_o, rd_o, stop_o, rx_en_o, addr_o, data_o} = '0;
      cs_o = 1'b1;
      mod_o = 1'b1;
   end
   // callers finish configuration before register 00 enters direct mode; later writes probe refusal or exit
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_o = 1'b1;
      addr_o = a;
      data_o = d;
      @(negedge clk_i);
      wr_o = 1'b0;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_i);
      rd_o = 1'b1;
      addr_o = a;
      @(negedge clk_i);
      d = rd_data_i;
      v = rd_valid_i;
      rd_o = 1'b0;
   endtask
   // the entering write carries no stop; a separate stop ends direct mode
   task automatic send_stop();
      @(negedge clk_i);
      stop_o = 1'b1;
      @(negedge clk_i);
      stop_o = 1'b0;
   endtask
   task automatic set_cs(input logic v);
      @(negedge clk_i);
      cs_o = v;
   endtask
   task automatic send_bit(input logic v);
      @(negedge clk_i);
      rx_en_o = 1'b0;
      mod_o = v;
   endtask
   task automatic listen();
      @(negedge clk_i);
      mod_o = 1'b1;
      rx_en_o = 1'b1;
   endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   import direct_mode_pkg::*;
   logic       clk_i, reset_i, spi_mode_i, rxd, v, miso, cmod, crx;
   logic       wr, rd, stop, cs, rx_en, mod, rd_valid;
   logic [7:0] addr, data, rd_data, d;
   int         fails, n_checks;
   int         cycles = 0;
   direct_mode_control DUT (.clk_i(clk_i), .reset_i(reset_i), .spi_mode_i(spi_mode_i),
      .wr_i(wr), .wr_addr_i(addr), .wr_data_i(data), .rd_i(rd), .rd_addr_i(addr),
      .rd_valid_o(rd_valid), .rd_data_o(rd_data), .stop_i(stop), .chip_select_pin_i(cs),
      .rx_enable_pin_i(rx_en), .modulation_input_pin_i(mod), .spi_miso_i(miso),
      .rx_direct_data_i(rxd), .coder_mod_i(cmod), .coder_rx_enable_i(crx),
      .serial_out_direct_pin_o(), .serial_out_direct_pin_oe_o(), .direct_active_o(),
      .rf_level_high_o(), .rx_enable_o(), .ext_shaping_o(), .phase_reversal_o(),
      .ask_depth_o(), .delimiter_cycles_o(), .delimiter_timed_o(), .tx_level_o(),
      .linear_shape_o(), .ask_rate_o(), .lpf_enable_o(), .aux_enable_o(), .aux_modulated_o(),
      .main_enable_o(), .main_modulated_o(), .lp_current_o(), .pa_enable_o(),
      .pa_differential_o(), .mixer_attenuator_o(), .mixer_low_supply_o(),
      .mixer_single_ended_o());
   host_model HOST (.clk_i(clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .wr_o(wr),
      .addr_o(addr), .data_o(data), .rd_o(rd), .stop_o(stop), .cs_o(cs), .rx_en_o(rx_en),
      .mod_o(mod));
   task automatic t_regs();
      logic [7:0] offs [7] = '{8'h00, 8'h0A, 8'h0B, 8'h15, 8'h16, 8'h17, 8'h30};
      foreach (offs[i]) begin
         HOST.read_reg(offs[i], d, v);
         `CHK({v, d}, 9'h100)
      end
      HOST.write_reg(RX_SPECIAL_SETTING_TWO_ADDR, 8'h83);
      `CHK({DUT.mixer_low_supply_o, DUT.mixer_attenuator_o}, 2'h3)
      `CHK(DUT.mixer_single_ended_o, 1'b1)
      HOST.write_reg(RX_SPECIAL_SETTING_TWO_ADDR, 8'h00);
      `CHK(DUT.mixer_single_ended_o, 1'b0)
      HOST.write_reg(REGULATOR_IO_CONTROL_ADDR, 8'h1D);
      `CHK({DUT.pa_differential_o, DUT.pa_enable_o, DUT.lp_current_o}, 5'h1D)
      $display("test regs done");
   endtask
   task automatic t_mod();
      // depth and delimiter are decoded from the register, so they lag it a cycle
      HOST.write_reg(MODULATOR_CONTROL_ADDR, 8'h3E);
      @(negedge clk_i);
      `CHK({DUT.delimiter_timed_o, DUT.ask_depth_o}, 7'h3E)
      HOST.write_reg(MODULATOR_CONTROL_ADDR, 8'h00);
      @(negedge clk_i);
      `CHK(DUT.ask_depth_o, 6'h01)
      HOST.write_reg(MODULATOR_CONTROL_ADDR, 8'h85);
      @(negedge clk_i);
      `CHK({DUT.phase_reversal_o, DUT.ask_depth_o}, 7'h3F)
      `CHK(DUT.delimiter_cycles_o, 12'h7E4)
      HOST.write_reg(MODULATOR_CONTROL_ADDR, 8'h7F);
      @(negedge clk_i);
      `CHK({DUT.phase_reversal_o, DUT.delimiter_cycles_o}, 13'h1C6C)
      HOST.write_reg(MODULATOR_SHAPE_ADDR, 8'hBF);
      `CHK({DUT.ask_rate_o, DUT.linear_shape_o, DUT.tx_level_o}, 8'hBF)
      HOST.write_reg(MODULATOR_ROUTING_ADDR, 8'h05);
      `CHK({DUT.lpf_enable_o, DUT.aux_modulated_o, DUT.main_modulated_o}, 3'h6)
      `CHK({DUT.aux_enable_o, DUT.main_enable_o}, 2'h3)
      $display("test mod done");
   endtask
   task automatic t_par();
      HOST.write_reg(MODULATOR_ROUTING_ADDR, 8'h02);
      `CHK(DUT.ext_shaping_o, 1'b0)
      {cmod, crx} = 2'h3;
      @(negedge clk_i);
      `CHK({DUT.rf_level_high_o, DUT.rx_enable_o}, 2'h3)
      HOST.write_reg(CHIP_STATUS_CONTROL_ADDR, 8'h40);
      `CHK({DUT.direct_active_o, DUT.ext_shaping_o}, 2'h3)
      `CHK(DUT.serial_out_direct_pin_oe_o, 1'b0)
      for (int i = 0; i < 4; i++) begin
         HOST.send_bit(i[0]);
         @(negedge clk_i);
         `CHK({DUT.rf_level_high_o, DUT.rx_enable_o}, {i[0], 1'b0})
      end
      HOST.listen();
      @(negedge clk_i);
      `CHK(DUT.rx_enable_o, 1'b1)
      HOST.write_reg(RX_SPECIAL_SETTING_TWO_ADDR, 8'hFF);
      HOST.read_reg(RX_SPECIAL_SETTING_TWO_ADDR, d, v);
      `CHK({v, DUT.mixer_attenuator_o}, 2'h0)
      HOST.send_stop();
      `CHK(DUT.direct_active_o, 1'b0)
      {cmod, crx} = 2'h0;
      HOST.read_reg(CHIP_STATUS_CONTROL_ADDR, d, v);
      `CHK({v, d}, 9'h100)
      `CHK({DUT.rf_level_high_o, DUT.rx_enable_o}, 2'h0)
      $display("test par done");
   endtask
   task automatic t_spi();
      {spi_mode_i, miso} = 2'h3;
      HOST.write_reg(CHIP_STATUS_CONTROL_ADDR, 8'h40);
      `CHK({DUT.direct_active_o, DUT.serial_out_direct_pin_o}, 2'h1)
      HOST.set_cs(1'b0);
      HOST.set_cs(1'b1);
      @(negedge clk_i);
      `CHK({DUT.direct_active_o, DUT.serial_out_direct_pin_oe_o}, 2'h3)
      for (int i = 1; i >= 0; i--) begin
         rxd = i[0];
         @(negedge clk_i);
         `CHK(DUT.serial_out_direct_pin_o, i[0])
      end
      HOST.read_reg(CHIP_STATUS_CONTROL_ADDR, d, v);
      `CHK(v, 1'b0)
      HOST.write_reg(CHIP_STATUS_CONTROL_ADDR, 8'h00);
      `CHK(DUT.direct_active_o, 1'b1)
      HOST.set_cs(1'b0);
      HOST.write_reg(CHIP_STATUS_CONTROL_ADDR, 8'h00);
      `CHK(DUT.direct_active_o, 1'b0)
      HOST.set_cs(1'b1);
      HOST.read_reg(CHIP_STATUS_CONTROL_ADDR, d, v);
      `CHK({v, d}, 9'h100)
      $display("test spi done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // generous ceiling: the whole sequence needs under a hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      {reset_i, spi_mode_i, rxd, miso, cmod, crx} = 6'h20;
      fails = 0;
      n_checks = 0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      t_regs();
      t_mod();
      t_par();
      t_spi();
      summarize();
   end
endmodule
